// File: qbsp_pkg.sv
// Shared constants and types for the burst-of-four static memory port.
package qbsp_pkg;

    // ==========================================================
    // Bus shape
    localparam int DW_WIDE = 36;
    localparam int DW_NARROW = 18;
    localparam int LANE_W = 9;
    localparam int LANES_WIDE = DW_WIDE / LANE_W;
    localparam int BEATS = 4;
    localparam int BEAT_W = 2;

    // ==========================================================
    // Timing
    localparam int SYS_PERIOD_NS = 8;
    localparam int DLL_LOCK_CYCLES = 2048;
    // Both output timing strobes high this long means they are tied off.
    localparam int C_HELD_NS = 1000;
    localparam int C_HELD_CYC = (C_HELD_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;

    // ==========================================================
    // Request pipeline taps, counted in primary strobe rising edges.
    localparam int AGE_0 = 0;
    localparam int AGE_1 = 1;
    localparam int AGE_2 = 2;
    localparam int AGES = 3;

    // One captured write beat with its lane masks.
    typedef struct packed {
        logic [DW_WIDE-1:0] data;
        logic [LANES_WIDE-1:0] mask_n;
    } qbsp_wbeat_s;

endpackage

// File: qbsp_ddr_out.sv
// Double data rate output cell: one register per edge, picked by the launching clock.
`timescale 1ns/1ns
module qbsp_ddr_out #(
    parameter int W = 8
) (
    input wire logic clk_rise, // Clock whose rising edge launches d_rise.
    input wire logic clk_fall, // Clock whose rising edge launches d_fall.
    input wire logic rst_n, // Synchronous reset, active low.
    input wire logic [W-1:0] d_rise, // Value launched on clk_rise.
    input wire logic [W-1:0] d_fall, // Value launched on clk_fall.
    output wire logic [W-1:0] q // Pin value.
);

    logic [W-1:0] q_rise;
    logic [W-1:0] q_fall;

    // ==========================================================
    // Edge registers
    // Each half lives in its own edge so that neither register sees two clocks.
    always_ff @(posedge clk_rise)
    begin
        if (!rst_n)
            q_rise <= '0;
        else
            q_rise <= d_rise;
    end

    always_ff @(posedge clk_fall)
    begin
        if (!rst_n)
            q_fall <= '0;
        else
            q_fall <= d_fall;
    end

    // The clock level selects the half; this is the usual output-cell mux.
    assign q = clk_rise ? q_rise : q_fall;

endmodule

// File: qbsp_sram_port.sv
// Pin-level model of a burst-of-four static memory with separate read and write ports.
`timescale 1ns/1ns
// What this block does
// R1: Address and read/write requests are taken on primary strobe rising edges only.
// R2: Write data is taken on rising edges of both primary and inverted strobe.
// R3: Controller drives inverted strobe as complement of primary, half a period apart.
// R4: Toggling output timing strobes launch the read data.
// R5: Echo strobes have edges aligned with read data transitions.
// R6: Echo strobes run continuously, also while read data is not driven.
// R7: Bypass input low bypasses the delay loop and drops its lock.
// R8: Bypass input high starts the delay loop; lock follows the lock interval.
// R9: With the delay loop off, read data starts one cycle after request.
// R10: In delay-loop-off operation the strobe stays at or below 167 MHz.
// R11: Address is ignored on edges without read or write request.
// R12: Write data is 18 bits narrow, 36 bits wide; upper lanes unused narrow.
// R13: Read data is 18 bits narrow and 36 bits wide.
// R14: Both output timing strobes held high: input strobes time the read data.
// R15: Read data is driven only in answer to read requests.
// R16: Store request low at a primary edge latches address, starts a write burst.
// R17: Fetch request low at a primary edge latches address, starts a read burst.
// R18: Low lane mask stores its byte lane; high leaves that byte unchanged.
// R19: Each lane mask is sampled on the same edge as its data beat.
// R20: Read requests come no more often than every other primary cycle.
// R21: Write beats follow one cycle after request, then inverted, primary, inverted.
// R22: Delay loop active: first read beat 1.5 cycles after request, then each edge.
// R23: An idle cycle does not cut short a read burst already running.
// R24: Narrow organisation ignores upper write lanes and leaves upper read lanes undriven.
module qbsp_sram_port
    import qbsp_pkg::*;
#(
    parameter bit WIDE = 1'b1,
    parameter int ADDR_W = 17
) (
    input wire logic clk_sys, // System clock, 125 MHz.
    input wire logic rstn, // Synchronous reset, active low.
    input wire logic k_clk, // Primary input strobe.
    input wire logic k_inv_clk, // Inverted input strobe.
    input wire logic c_clk, // Output timing strobe.
    input wire logic c_inv_clk, // Inverted output timing strobe.
    input wire logic doff_n, // Delay loop bypass, low bypasses and resets.
    input wire logic [ADDR_W-1:0] addr_bus, // Burst address.
    input wire logic fetch_req_n, // Read request, active low.
    input wire logic store_req_n, // Write request, active low.
    input wire logic [DW_WIDE-1:0] write_data_in, // Write data beats.
    input wire logic [LANES_WIDE-1:0] lane_store_mask_n, // Lane masks, active low.
    output wire logic [DW_WIDE-1:0] read_data_out, // Read data beats.
    output wire logic [DW_WIDE-1:0] read_data_oe, // High while a data bit is driven.
    output wire logic echo_strobe, // Echo of the read launch clock.
    output wire logic echo_strobe_inv, // Inverted echo.
    output logic dll_locked, // Delay loop has locked.
    output logic out_timing_from_input // Read data timed by the input strobes.
);

    localparam int DW = WIDE ? DW_WIDE : DW_NARROW;
    localparam int LANES = DW / LANE_W;
    localparam int IDX_W = ADDR_W + BEAT_W;
    localparam int MEM_WORDS = 1 << IDX_W;
    localparam int LOCK_W = $clog2(DLL_LOCK_CYCLES + 1);
    localparam int HELD_W = $clog2(C_HELD_CYC + 1);
    localparam int OUT_W = 2 * DW_WIDE + 2;
    localparam logic [LOCK_W-1:0] LOCK_LAST = LOCK_W'(DLL_LOCK_CYCLES - 1);
    localparam logic [HELD_W-1:0] HELD_LAST = HELD_W'(C_HELD_CYC - 1);
    localparam logic [DW_WIDE-1:0] LANE_ENABLES = DW_WIDE'((64'h1 << DW) - 64'h1);

    generate
        if (ADDR_W < 1 || ADDR_W > 20)
        begin : g_bad_addr
            $error("qbsp_sram_port: ADDR_W must lie between 1 and 20");
        end
    endgenerate

    // Memory word index of one beat within a burst.
    function automatic logic [IDX_W-1:0] mem_idx(input logic [ADDR_W-1:0] a, input int b);
        mem_idx = {a, BEAT_W'(b)};
    endfunction

    // ==========================================================
    // Link-side reset and bypass synchronisers
    logic rst_k_meta;
    logic rst_k_n;
    logic doff_meta;
    logic doff_s;
    logic [LOCK_W-1:0] lock_cnt;

    // The link strobe may stand still, so the reset only reaches it when it runs.
    always_ff @(posedge k_clk)
    begin
        rst_k_meta <= rstn;
        rst_k_n <= rst_k_meta;
        doff_meta <= doff_n;
        doff_s <= doff_meta;
    end

    // ==========================================================
    // Delay loop lock tracking
    // A low bypass level drops any lock at once; the count restarts on its rise.
    always_ff @(posedge k_clk)
    begin
        if (!rst_k_n || !doff_s)
        begin
            lock_cnt <= '0; // [R7]
            dll_locked <= 1'b0; // [R7]
        end
        else if (!dll_locked)
        begin
            lock_cnt <= lock_cnt + LOCK_W'(1); // [R8]
            if (lock_cnt == LOCK_LAST)
                dll_locked <= 1'b1; // [R8]
        end
    end

    // ==========================================================
    // Output timing strobe watch
    logic [1:0] c_meta;
    logic [1:0] c_s;
    logic [HELD_W-1:0] held_cnt;

    always_ff @(posedge clk_sys)
    begin
        c_meta <= {c_clk, c_inv_clk};
        c_s <= c_meta;
    end

    // Both strobes must stay high for a long stretch before we switch, so a
    // momentary overlap of two running strobes never swaps the launch clock.
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            held_cnt <= '0;
            out_timing_from_input <= 1'b1;
        end
        else if (c_s != 2'b11)
        begin
            held_cnt <= '0;
            out_timing_from_input <= 1'b0; // [R4]
        end
        else if (held_cnt == HELD_LAST)
            out_timing_from_input <= 1'b1; // [R14]
        else
            held_cnt <= held_cnt + HELD_W'(1);
    end

    // Launch clocks; the select follows the output timing strobe watch and can change at any time after power-up.
    wire launch_rise_clk = out_timing_from_input ? k_clk : c_clk; // [R14] [R4]
    wire launch_fall_clk = out_timing_from_input ? k_inv_clk : c_inv_clk; // [R14] [R4]

    // ==========================================================
    // Memory array
    logic [DW-1:0] mem [MEM_WORDS];

    // ==========================================================
    // Read request pipeline
    logic [AGES-1:0] rd_age;
    logic [AGES-1:0] rd_sel;
    logic fill_sel;
    logic [DW-1:0] rd_buf [2][BEATS];
    wire rd_take = !fetch_req_n; // [R17]

    // Ages shift every edge, so a burst runs out even when no request follows.
    always_ff @(posedge k_clk)
    begin
        if (!rst_k_n)
        begin
            rd_age <= '0;
            rd_sel <= '0;
            fill_sel <= 1'b0;
        end
        else
        begin
            rd_age <= {rd_age[AGES-2:0], rd_take}; // [R1] [R23]
            rd_sel <= {rd_sel[AGES-2:0], fill_sel};
            if (rd_take)
                fill_sel <= ~fill_sel;
        end
    end

    // Two burst buffers let the next read fetch while the last beats still leave.
    always_ff @(posedge k_clk)
    begin
        if (rd_take)
        begin
            for (int b = 0; b < BEATS; b++)
                rd_buf[fill_sel][b] <= mem[mem_idx(addr_bus, b)]; // [R17] [R11]
        end
    end

    // ==========================================================
    // Read beat selection per launch edge
    logic rise_vld;
    logic fall_vld;
    logic [DW-1:0] rise_beat;
    logic [DW-1:0] fall_beat;

    // Primary-edge beats: 1 and 3 with the loop on, 0 and 2 with it off.
    always_comb
    begin
        rise_vld = 1'b0;
        rise_beat = '0;
        if (doff_s)
        begin
            if (rd_age[AGE_1])
            begin
                rise_vld = 1'b1;
                rise_beat = rd_buf[rd_sel[AGE_1]][1]; // [R22]
            end
            else if (rd_age[AGE_2])
            begin
                rise_vld = 1'b1;
                rise_beat = rd_buf[rd_sel[AGE_2]][3]; // [R22] [R23]
            end
        end
        else if (rd_age[AGE_0])
        begin
            rise_vld = 1'b1;
            rise_beat = rd_buf[rd_sel[AGE_0]][0]; // [R9]
        end
        else if (rd_age[AGE_1])
        begin
            rise_vld = 1'b1;
            rise_beat = rd_buf[rd_sel[AGE_1]][2]; // [R9] [R23]
        end
    end

    // Inverted-edge beats: 0 and 2 with the loop on, 1 and 3 with it off.
    always_comb
    begin
        fall_vld = 1'b0;
        fall_beat = '0;
        if (rd_age[AGE_1])
        begin
            fall_vld = 1'b1;
            fall_beat = rd_buf[rd_sel[AGE_1]][doff_s ? 0 : 1]; // [R22] [R9]
        end
        else if (rd_age[AGE_2])
        begin
            fall_vld = 1'b1;
            fall_beat = rd_buf[rd_sel[AGE_2]][doff_s ? 2 : 3]; // [R22] [R9] [R23]
        end
    end

    // ==========================================================
    // Output cell: data, enables and echo strobes share one launch path
    logic [OUT_W-1:0] out_rise;
    logic [OUT_W-1:0] out_fall;
    logic [OUT_W-1:0] out_pins;

    // Upper lanes of the narrow part are neither driven nor enabled.
    always_comb
    begin
        out_rise = {2'b10, LANE_ENABLES & {DW_WIDE{rise_vld}}, DW_WIDE'(rise_beat)}; // [R15] [R24]
        out_fall = {2'b01, LANE_ENABLES & {DW_WIDE{fall_vld}}, DW_WIDE'(fall_beat)}; // [R15] [R24]
    end

    qbsp_ddr_out #(
        .W(OUT_W)
    ) u_out (
        .clk_rise(launch_rise_clk),
        .clk_fall(launch_fall_clk),
        .rst_n(rst_k_n),
        .d_rise(out_rise),
        .d_fall(out_fall),
        .q(out_pins)
    );

    // Echo bits toggle with every launch edge whatever the enables do.
    assign echo_strobe = out_pins[OUT_W-1]; // [R5] [R6]
    assign echo_strobe_inv = out_pins[OUT_W-2]; // [R5] [R6]
    assign read_data_oe = out_pins[2*DW_WIDE-1:DW_WIDE]; // [R13]
    assign read_data_out = out_pins[DW_WIDE-1:0]; // [R4] [R13]

    // ==========================================================
    // Write request pipeline
    logic [AGES-1:0] wr_age;
    logic [ADDR_W-1:0] wr_addr [AGES];
    qbsp_wbeat_s beat_rise [2];
    qbsp_wbeat_s beat_fall [2];
    qbsp_wbeat_s in_beat;
    qbsp_wbeat_s burst [BEATS];

    // Narrow parts mask the unused upper lanes off at capture.
    always_comb
    begin
        in_beat.data = write_data_in & LANE_ENABLES; // [R12] [R24]
        in_beat.mask_n = lane_store_mask_n | ~LANES_WIDE'((5'h1 << LANES) - 5'h1); // [R24]
    end

    // Address is only latched with a request, so idle edges leave it alone.
    always_ff @(posedge k_clk)
    begin
        if (!rst_k_n)
        begin
            wr_age <= '0;
            wr_addr[AGE_0] <= '0;
        end
        else
        begin
            wr_age <= {wr_age[AGES-2:0], !store_req_n}; // [R16] [R1]
            if (!store_req_n)
                wr_addr[AGE_0] <= addr_bus; // [R16] [R11]
        end
        wr_addr[AGE_1] <= wr_addr[AGE_0];
        wr_addr[AGE_2] <= wr_addr[AGE_1];
    end

    // Beats 0 and 2 on the primary edges after the request.
    always_ff @(posedge k_clk)
    begin
        if (wr_age[AGE_0])
            beat_rise[0] <= in_beat; // [R21] [R2] [R19]
        if (wr_age[AGE_1])
            beat_rise[1] <= in_beat; // [R21] [R2] [R19]
    end

    // Beats 1 and 3 on the inverted edges; masks ride with their data.
    always_ff @(posedge k_inv_clk)
    begin
        if (wr_age[AGE_1])
            beat_fall[0] <= in_beat; // [R21] [R2] [R19]
        if (wr_age[AGE_2])
            beat_fall[1] <= in_beat; // [R21] [R2] [R19]
    end

    always_comb
    begin
        burst[0] = beat_rise[0];
        burst[1] = beat_fall[0];
        burst[2] = beat_rise[1];
        burst[3] = beat_fall[1];
    end

    // ==========================================================
    // Burst commit
    // The whole burst lands at once, half a cycle after its last beat is taken;
    // a read of that address before then still returns the old contents.
    always_ff @(posedge k_clk)
    begin
        if (rst_k_n && wr_age[AGE_2])
        begin
            for (int b = 0; b < BEATS; b++)
            begin
                for (int l = 0; l < LANES; l++)
                begin
                    if (!burst[b].mask_n[l])
                        mem[mem_idx(wr_addr[AGE_2], b)][l*LANE_W +: LANE_W] <=
                            burst[b].data[l*LANE_W +: LANE_W]; // [R18]
                end
            end
        end
    end

endmodule

// File: qbsp_sram_port_monitor.sv
// Concurrent checks on the pins of the burst-of-four memory port.
`timescale 1ns/1ns
module qbsp_sram_port_monitor
    import qbsp_pkg::*;
(
    input wire logic clk_sys, // System clock.
    input wire logic rstn, // Reset, active low.
    input wire logic k_clk, // Primary input strobe.
    input wire logic c_clk, // Output timing strobe.
    input wire logic c_inv_clk, // Inverted output timing strobe.
    input wire logic doff_n, // Delay loop bypass, active low.
    input wire logic fetch_req_n, // Read request, active low.
    input wire logic [DW_WIDE-1:0] read_data_oe, // Read drive enables.
    input wire logic echo_strobe, // Echo strobe.
    input wire logic echo_strobe_inv, // Inverted echo strobe.
    input wire logic dll_locked, // Delay loop lock flag.
    input wire logic out_timing_from_input // Read data timed by input strobes.
);
    // ==========================================================
    // Helper counters
    int unsigned up_cnt;
    int unsigned c_hi_cnt;
    int unsigned doff_cnt;

    // The link side leaves reset a few strobe cycles late, so echo checks wait.
    always_ff @(posedge clk_sys)
    begin
        up_cnt <= !rstn ? 0 : (up_cnt < 100 ? up_cnt + 1 : up_cnt);
    end

    // Cycles for which both output timing strobes have been high.
    always_ff @(posedge clk_sys)
    begin
        c_hi_cnt <= (!rstn || !(c_clk && c_inv_clk)) ? 0 :
            (c_hi_cnt < 200 ? c_hi_cnt + 1 : c_hi_cnt);
    end

    // Strobe rises seen with the bypass input high; saturates past the lock bound.
    always_ff @(posedge k_clk)
    begin
        doff_cnt <= (!rstn || !doff_n) ? 0 : (doff_cnt < 3000 ? doff_cnt + 1 : doff_cnt);
    end

    // ==========================================================
    // Assertions
    AST_ECHO_PAIR:
        assert property (@(posedge clk_sys) disable iff (!rstn)
            up_cnt >= 100 |-> echo_strobe_inv == !echo_strobe)
        else $error("echo strobes not complementary");
    AST_ECHO_RUNS:
        assert property (@(posedge clk_sys) disable iff (!rstn)
            up_cnt >= 100 |-> echo_strobe == k_clk)
        else $error("echo strobe does not follow the launch strobe");
    AST_OE_WHOLE:
        assert property (@(posedge clk_sys) disable iff (!rstn)
            read_data_oe == '0 || read_data_oe == '1)
        else $error("read lanes driven partly");
    AST_OE_IDLE:
        assert property (@(posedge k_clk) disable iff (!rstn)
            $past(fetch_req_n) && $past(fetch_req_n, 2) && $past(fetch_req_n, 3)
            |-> read_data_oe == '0)
        else $error("read data driven without a read request");
    AST_LAT_OFF:
        assert property (@(posedge k_clk) disable iff (!rstn)
            !fetch_req_n && !doff_n && !$past(doff_n) && !$past(doff_n, 3)
            |-> ##2 read_data_oe == '1 ##1 read_data_oe == '1 ##1 read_data_oe == '0)
        else $error("bypassed read window wrong");
    AST_LAT_ON:
        assert property (@(posedge k_clk) disable iff (!rstn)
            !fetch_req_n && doff_n && $past(doff_n) && $past(doff_n, 3)
            |-> ##1 read_data_oe == '0 ##1 read_data_oe == '1 [*2] ##1 read_data_oe == '0)
        else $error("locked read window wrong");
    AST_LOCK_DROP:
        assert property (@(posedge k_clk) disable iff (!rstn)
            !doff_n [*4] |-> !dll_locked)
        else $error("lock kept while bypassed");
    AST_LOCK_EARLY:
        assert property (@(posedge k_clk) disable iff (!rstn)
            $rose(dll_locked) |-> doff_cnt >= 2048 && doff_cnt <= 2056)
        else $error("lock flag rose at the wrong count");
    AST_LOCK_LATE:
        assert property (@(posedge k_clk) disable iff (!rstn)
            doff_cnt == 2060 |-> dll_locked)
        else $error("lock flag late");
    AST_OUT_SEL:
        assert property (@(posedge clk_sys) disable iff (!rstn)
            c_hi_cnt >= 130 |-> out_timing_from_input)
        else $error("input strobes not timing reads");
endmodule

bind qbsp_sram_port qbsp_sram_port_monitor u_mon (.clk_sys(clk_sys), .rstn(rstn),
    .k_clk(k_clk), .c_clk(c_clk), .c_inv_clk(c_inv_clk), .doff_n(doff_n),
    .fetch_req_n(fetch_req_n), .read_data_oe(read_data_oe), .echo_strobe(echo_strobe),
    .echo_strobe_inv(echo_strobe_inv), .dll_locked(dll_locked),
    .out_timing_from_input(out_timing_from_input));

// File: qbsp_ctrl_model.sv
// Memory controller model: makes the input strobes and runs write and read bursts.
`timescale 1ns/1ns
module qbsp_ctrl_model
    import qbsp_pkg::*;
#(
    parameter int AW = 6
) (
    output logic k_clk, // Primary input strobe.
    output logic k_inv_clk, // Inverted input strobe.
    output logic [AW-1:0] addr_bus, // Burst address.
    output logic fetch_req_n, // Read request, active low.
    output logic store_req_n, // Write request, active low.
    output logic [DW_WIDE-1:0] write_data_in, // Write beats.
    output logic [LANES_WIDE-1:0] lane_store_mask_n, // Lane masks, active low.
    input wire logic [DW_WIDE-1:0] read_data_out, // Read beats.
    input wire logic [DW_WIDE-1:0] read_data_oe // Read drive enables.
);
    // ==========================================================
    // Strobes run free, since the device locks its delay loop to them.
    initial
    begin
        {addr_bus, fetch_req_n, store_req_n} = {{AW{1'b0}}, 2'b11};
        {write_data_in, lane_store_mask_n} = '1;
        k_clk = 1'b0;
        k_inv_clk = 1'b1;
        #3;
        forever
        begin
            #80 k_clk = ~k_clk;
            k_inv_clk = ~k_clk;
        end
    end

    // ==========================================================
    // Bursts; inputs change mid half period, released lines show the inverse.
    task automatic write_burst(input logic [AW-1:0] a, input logic [4*DW_WIDE-1:0] d,
        input logic [4*LANES_WIDE-1:0] m);
        @(posedge k_clk);
        #40 {addr_bus, store_req_n} = {a, 1'b0};
        #160 {addr_bus, store_req_n} = {~a, 1'b1};
        #80;
        for (int i = 0; i < BEATS; i++)
        begin
            write_data_in = d[i*DW_WIDE +: DW_WIDE];
            lane_store_mask_n = m[i*LANES_WIDE +: LANES_WIDE];
            #80;
        end
        {write_data_in, lane_store_mask_n} = ~{write_data_in, lane_store_mask_n};
    endtask

    // The first sample falls half a cycle later when the delay loop runs.
    task automatic read_burst(input logic [AW-1:0] a, input logic dll_on,
        output logic [4*DW_WIDE-1:0] q, output logic [5:0] oe_pat);
        @(posedge k_clk);
        #40 {addr_bus, fetch_req_n} = {a, 1'b0};
        #160 {addr_bus, fetch_req_n} = {~a, 1'b1};
        #(dll_on ? 160 : 80);
        oe_pat[0] = (read_data_oe !== '0);
        for (int i = 0; i < BEATS; i++)
        begin
            #80 q[i*DW_WIDE +: DW_WIDE] = read_data_out;
            oe_pat[i+1] = (read_data_oe === '1);
        end
        #80 oe_pat[5] = (read_data_oe !== '0);
    endtask
endmodule

// File: tb_top.sv
// Self-checking bench for the burst-of-four memory port.
`timescale 1ns/1ns
module tb_top
    import qbsp_pkg::*;
();
    localparam int AW = 6;
    logic clk_sys, rstn, doff_n, k_clk, k_inv_clk, fetch_req_n, store_req_n;
    logic dll_locked, out_timing_from_input;
    logic c_on;
    // Output timing strobes stay tied high until c_on, then copy the input pair.
    wire c_clk = c_on ? k_clk : 1'b1;
    wire c_inv_clk = c_on ? k_inv_clk : 1'b1;
    logic [AW-1:0] addr_bus, a;
    logic [DW_WIDE-1:0] write_data_in, read_data_out, read_data_oe;
    logic [LANES_WIDE-1:0] lane_store_mask_n;
    logic [DW_WIDE-1:0] mem [0:(1<<(AW+BEAT_W))-1];
    int err_count, samples_checked, n;

    // ==========================================================
    // Clock, partner and design
    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    qbsp_ctrl_model #(.AW(AW)) u_ctrl (.k_clk(k_clk), .k_inv_clk(k_inv_clk),
        .addr_bus(addr_bus), .fetch_req_n(fetch_req_n), .store_req_n(store_req_n),
        .write_data_in(write_data_in), .lane_store_mask_n(lane_store_mask_n),
        .read_data_out(read_data_out), .read_data_oe(read_data_oe));

    qbsp_sram_port #(.WIDE(1'b1), .ADDR_W(AW)) u_dut (.clk_sys(clk_sys), .rstn(rstn),
        .k_clk(k_clk), .k_inv_clk(k_inv_clk), .c_clk(c_clk), .c_inv_clk(c_inv_clk),
        .doff_n(doff_n), .addr_bus(addr_bus), .fetch_req_n(fetch_req_n),
        .store_req_n(store_req_n), .write_data_in(write_data_in),
        .lane_store_mask_n(lane_store_mask_n), .read_data_out(read_data_out),
        .read_data_oe(read_data_oe), .echo_strobe(), .echo_strobe_inv(),
        .dll_locked(dll_locked), .out_timing_from_input(out_timing_from_input));

    // ==========================================================
    // Expectation, comparison and closing
    function automatic logic [DW_WIDE-1:0] merge(input logic [DW_WIDE-1:0] old_w, new_w,
        input logic [LANES_WIDE-1:0] m_n);
        for (int l = 0; l < LANES_WIDE; l++)
        begin
            if (m_n[l] == 1'b0)
                old_w[l*LANE_W +: LANE_W] = new_w[l*LANE_W +: LANE_W];
        end
        return old_w;
    endfunction

    task automatic check(input string what, input logic [DW_WIDE-1:0] seen, exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Write a random burst under the masks, then read it back and compare.
    task automatic wr_rd(input logic [AW-1:0] ad, input logic [4*LANES_WIDE-1:0] m);
        logic [4*DW_WIDE-1:0] d, q;
        logic [5:0] oe_pat;
        d = {16'($urandom), $urandom, $urandom, $urandom, $urandom};
        u_ctrl.write_burst(ad, d, m);
        for (int b = 0; b < BEATS; b++)
            mem[{ad, b[1:0]}] = merge(mem[{ad, b[1:0]}], d[b*DW_WIDE +: DW_WIDE],
                m[b*LANES_WIDE +: LANES_WIDE]);
        u_ctrl.read_burst(ad, doff_n, q, oe_pat);
        for (int b = 0; b < BEATS; b++)
            check("read beat", q[b*DW_WIDE +: DW_WIDE], mem[{ad, b[1:0]}]);
        check("drive window", 36'(oe_pat), 36'h1E);
    endtask

    // ==========================================================
    // Main sequence; reset spans three strobe cycles so the link side sees it.
    initial
    begin
        {err_count, samples_checked, rstn, doff_n, c_on} = '0;
        void'($urandom(32'h1E85));
        repeat (60) @(negedge clk_sys);
        rstn = 1'b1;
        repeat (100) @(negedge clk_sys);
        for (int t = 0; t < 6; t++)
        begin
            a = (t == 0) ? 6'h00 : (t == 1) ? 6'h3F : 6'($urandom);
            wr_rd(a, 16'h0000);
            wr_rd(a, (t == 0) ? 16'hFFFF : 16'($urandom));
        end
        $display("test bypassed loop done");
        @(negedge clk_sys) doff_n = 1'b1;
        for (n = 0; n < 2200 && dll_locked !== 1'b1; n++)
            @(posedge k_clk);
        check("lock flag", 36'(dll_locked), 36'h1);
        if (dll_locked !== 1'b1)
            finish_test();
        for (int t = 0; t < 4; t++)
        begin
            a = 6'($urandom);
            wr_rd(a, 16'h0000);
            wr_rd(a, 16'($urandom));
        end
        $display("test locked loop done");
        @(negedge clk_sys) doff_n = 1'b0;
        repeat (4) @(posedge k_clk);
        #1 check("lock flag", 36'(dll_locked), 36'h0);
        wr_rd(6'($urandom), 16'($urandom));
        check("timing source", 36'(out_timing_from_input), 36'h1);
        $display("test bypass again done");
        @(negedge clk_sys) c_on = 1'b1;
        repeat (8) @(negedge clk_sys);
        check("timing source", 36'(out_timing_from_input), 36'h0);
        wr_rd(6'($urandom), 16'($urandom));
        $display("test output strobes done");
        finish_test();
    end
endmodule
